// [common/dpc_cfg.svh]
// Purpose: offsets, field positions, reset values and counts of the defect pixel table control
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   included by its bare name
// Contract
// - on/off switch for table-based pixel replacement
// - three methods: average, highlight, zero
// - average uses neighbours; highlight forces maximum value
// - entry count readable and writable by host
// - entry selector picks entry for coordinate access
// - column access reads/writes selected entry
// - row access reads/writes selected entry
// - coordinates relative to full sensor image
// - edits staged; active table unchanged until commit
// - commit copies staged table into volatile active
// - transfer during streaming may briefly corrupt frames
// - persist overwrites stored table with current table
// - power-up loads stored table as active; here reset first reloads the stored table with the factory table
// - restore returns table to factory calibration
// - restore overwrites active and stored copies
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH
`define DPC_OFF_CTRL        8'h00
`define DPC_OFF_COUNT       8'h04
`define DPC_OFF_SELECT      8'h08
`define DPC_OFF_COLUMN      8'h0c
`define DPC_OFF_ROW         8'h10
`define DPC_OFF_COMMAND     8'h14
`define DPC_OFF_STATUS      8'h18
`define DPC_CTRL_EN_BIT     0
`define DPC_CTRL_METHOD_LSB 1
`define DPC_CMD_COMMIT_BIT  0
`define DPC_CMD_PERSIST_BIT 1
`define DPC_CMD_RESTORE_BIT 2
`define DPC_STAT_BUSY_BIT   0
`define DPC_STAT_ACT_LSB    8
`define DPC_RST_EN          1'b0
`define DPC_RESP_OKAY       2'b00
`define DPC_RESP_SLVERR     2'b10
`define DPC_FIFO_DEPTH      16
`endif

// [common/dpc_pkg.sv]
// Purpose: shared types of the defect pixel table control
// Assumes: nothing
// Notes:   encodings follow declaration order
package dpc_pkg;
  typedef enum logic [1:0] {
    method_average,
    method_highlight,
    method_zero
  } method_t;
  typedef enum logic [2:0] {
    xf_boot,
    xf_idle,
    xf_commit,
    xf_persist,
    xf_restore
  } xfer_t;
endpackage

// [hw/pixel_fifo.sv]
// Purpose: synchronous fifo between the correction stage and the image path
// Assumes: one clock, synchronous active-high reset
// Notes:   depth is a power of two
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } fifo_t;
  fifo_t s_q;
  fifo_t s_d;
  logic  push;
  logic  pop;

  assign in_ready  = (s_q.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// [hw/defect_pixel_table_control.sv]
// Purpose: defect pixel table with staged edits, commit, persist and factory restore, plus pixel replacement
// Assumes: pixel stream and register bus on one clock; stored table held in flops that reset and the restore command load with the factory table
// Notes:   a transfer copies one entry per clock, entries from index 0 upward
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_cfg.svh"
module defect_pixel_table_control #(
  parameter int                         ENTRIES       = 8,
  parameter int                         PIX_W         = 12,
  parameter int                         COORD_W       = 16,
  parameter int                         FACTORY_COUNT = 0,
  parameter logic [ENTRIES*COORD_W-1:0] FACTORY_COLS  = '0,
  parameter logic [ENTRIES*COORD_W-1:0] FACTORY_ROWS  = '0
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               s_valid,
  output logic                    s_ready,
  input  wire logic [PIX_W-1:0]   s_pixel,
  input  wire logic [COORD_W-1:0] s_col,
  input  wire logic [COORD_W-1:0] s_row,
  input  wire logic               s_line_end,
  input  wire logic [COORD_W-1:0] roi_offset_col,
  input  wire logic [COORD_W-1:0] roi_offset_row,
  output logic                    m_valid,
  input  wire logic               m_ready,
  output logic [PIX_W-1:0]        m_pixel,
  output logic                    m_line_end
);
  localparam int CW = $clog2(ENTRIES+1);
  localparam int SW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam logic [ENTRIES-1:0][COORD_W-1:0] FAC_COL = FACTORY_COLS;
  localparam logic [ENTRIES-1:0][COORD_W-1:0] FAC_ROW = FACTORY_ROWS;
  localparam logic [CW-1:0] FAC_CNT = CW'(FACTORY_COUNT);
  localparam logic [SW-1:0] LAST_IDX = SW'(ENTRIES-1);

  typedef logic [ENTRIES-1:0][COORD_W-1:0] coords_t;
  typedef struct packed {
    logic             en;
    dpc_pkg::method_t method;
    logic [CW-1:0]    count;
    logic [CW-1:0]    act_count;
    logic [CW-1:0]    nv_count;
    logic [15:0]      sel;
    coords_t          stg_col;
    coords_t          stg_row;
    coords_t          act_col;
    coords_t          act_row;
    coords_t          nv_col;
    coords_t          nv_row;
    dpc_pkg::xfer_t   st;
    logic [SW-1:0]    idx;
    logic             aw_held;
    logic [7:0]       awaddr;
    logic             w_held;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic             held;
    logic             held_end;
    logic             held_def;
    logic [PIX_W-1:0] held_pix;
    logic             left_ok;
    logic [PIX_W-1:0] left_pix;
  } state_t;

  state_t             s_q;
  state_t             s_d;
  logic               wr_go;
  logic               rd_go;
  logic [31:0]        rd_word;
  logic               rd_ok;
  logic               sel_ok;
  logic [COORD_W-1:0] abs_col;
  logic [COORD_W-1:0] abs_row;
  logic               hit;
  logic               in_fire;
  logic               emit;
  logic               fifo_in_ready;
  logic               right_ok;
  logic [PIX_W:0]     pair_sum;
  logic [PIX_W-1:0]   fix_pix;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  assign s_axi_awready = !s_q.aw_held;
  assign s_axi_wready  = !s_q.w_held;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = s_q.rdata;
  assign wr_go         = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign rd_go         = s_axi_arvalid && !s_q.rvalid;
  assign sel_ok        = (s_q.sel < 16'(ENTRIES));

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      `DPC_OFF_CTRL: begin
        rd_word[`DPC_CTRL_EN_BIT] = s_q.en;
        rd_word[`DPC_CTRL_METHOD_LSB +: 2] = s_q.method;
      end
      `DPC_OFF_COUNT:   rd_word[CW-1:0] = s_q.count;
      `DPC_OFF_SELECT:  rd_word[15:0] = s_q.sel;
      `DPC_OFF_COLUMN: begin
        if (sel_ok) begin
          rd_word[COORD_W-1:0] = s_q.stg_col[s_q.sel[SW-1:0]];
        end
      end
      `DPC_OFF_ROW: begin
        if (sel_ok) begin
          rd_word[COORD_W-1:0] = s_q.stg_row[s_q.sel[SW-1:0]];
        end
      end
      `DPC_OFF_COMMAND: rd_word = '0;
      `DPC_OFF_STATUS: begin
        rd_word[`DPC_STAT_BUSY_BIT] = (s_q.st != dpc_pkg::xf_idle);
        rd_word[`DPC_STAT_ACT_LSB +: CW] = s_q.act_count;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // defect lookup on full-sensor coordinates
  // ----------------------------------------------------------------
  assign abs_col = roi_offset_col + s_col;
  assign abs_row = roi_offset_row + s_row;

  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      if ((CW'(i) < s_q.act_count) && (s_q.act_col[i] == abs_col) && (s_q.act_row[i] == abs_row)) begin
        hit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // replacement stage: one pixel is held until its right neighbour arrives or it ends the line
  // ----------------------------------------------------------------
  assign s_ready  = !s_q.held || fifo_in_ready;
  assign in_fire  = s_valid && s_ready;
  assign emit     = s_q.held && fifo_in_ready && (in_fire || s_q.held_end);
  assign right_ok = in_fire && !s_q.held_end;
  assign pair_sum = {1'b0, s_q.left_pix} + {1'b0, s_pixel};

  always_comb begin
    fix_pix = s_q.held_pix;
    if (s_q.en && s_q.held_def) begin
      unique case (s_q.method)
        dpc_pkg::method_average: begin
          if (s_q.left_ok && right_ok) begin
            fix_pix = pair_sum[PIX_W:1];
          end else if (s_q.left_ok) begin
            fix_pix = s_q.left_pix;
          end else if (right_ok) begin
            fix_pix = s_pixel;
          end
        end
        dpc_pkg::method_highlight: fix_pix = '1;
        dpc_pkg::method_zero:      fix_pix = '0;
        default:                   fix_pix = s_q.held_pix;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    wv   = '0;
    s_d  = s_q;
    // table transfer, one entry per clock; pixels see a half-copied table during boot, commit and restore
    unique case (s_q.st)
      dpc_pkg::xf_boot: begin
        s_d.stg_col[s_q.idx] = s_q.nv_col[s_q.idx];
        s_d.stg_row[s_q.idx] = s_q.nv_row[s_q.idx];
        s_d.act_col[s_q.idx] = s_q.nv_col[s_q.idx];
        s_d.act_row[s_q.idx] = s_q.nv_row[s_q.idx];
        s_d.count            = s_q.nv_count;
        s_d.act_count        = s_q.nv_count;
      end
      dpc_pkg::xf_commit: begin
        s_d.act_col[s_q.idx] = s_q.stg_col[s_q.idx];
        s_d.act_row[s_q.idx] = s_q.stg_row[s_q.idx];
      end
      dpc_pkg::xf_persist: begin
        s_d.nv_col[s_q.idx] = s_q.stg_col[s_q.idx];
        s_d.nv_row[s_q.idx] = s_q.stg_row[s_q.idx];
      end
      dpc_pkg::xf_restore: begin
        s_d.stg_col[s_q.idx] = FAC_COL[s_q.idx];
        s_d.stg_row[s_q.idx] = FAC_ROW[s_q.idx];
        s_d.act_col[s_q.idx] = FAC_COL[s_q.idx];
        s_d.act_row[s_q.idx] = FAC_ROW[s_q.idx];
        s_d.nv_col[s_q.idx]  = FAC_COL[s_q.idx];
        s_d.nv_row[s_q.idx]  = FAC_ROW[s_q.idx];
      end
      dpc_pkg::xf_idle: ;
    endcase
    if (s_q.st != dpc_pkg::xf_idle) begin
      s_d.idx = (s_q.idx == LAST_IDX) ? '0 : s_q.idx + 1'b1;
      if (s_q.idx == LAST_IDX) begin
        s_d.st = dpc_pkg::xf_idle;
      end
    end
    // write channel capture, address and data in either order
    if (s_axi_awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = `DPC_RESP_OKAY;
      unique case (s_q.awaddr)
        `DPC_OFF_CTRL: begin
          wv = merge({29'h0, s_q.method, s_q.en}, s_q.wdata, s_q.wstrb);
          s_d.en = wv[`DPC_CTRL_EN_BIT];
          // the unused fourth code is ignored so the method stays legal
          if (wv[`DPC_CTRL_METHOD_LSB +: 2] != 2'h3) begin
            s_d.method = dpc_pkg::method_t'(wv[`DPC_CTRL_METHOD_LSB +: 2]);
          end
        end
        `DPC_OFF_COUNT: begin
          wv = merge(32'(s_q.count), s_q.wdata, s_q.wstrb);
          s_d.count = (wv > 32'(ENTRIES)) ? CW'(ENTRIES) : wv[CW-1:0];
        end
        `DPC_OFF_SELECT: begin
          wv = merge({16'h0, s_q.sel}, s_q.wdata, s_q.wstrb);
          s_d.sel = wv[15:0];
        end
        `DPC_OFF_COLUMN: begin
          if (sel_ok) begin
            wv = merge(32'(s_q.stg_col[s_q.sel[SW-1:0]]), s_q.wdata, s_q.wstrb);
            s_d.stg_col[s_q.sel[SW-1:0]] = wv[COORD_W-1:0];
          end
        end
        `DPC_OFF_ROW: begin
          if (sel_ok) begin
            wv = merge(32'(s_q.stg_row[s_q.sel[SW-1:0]]), s_q.wdata, s_q.wstrb);
            s_d.stg_row[s_q.sel[SW-1:0]] = wv[COORD_W-1:0];
          end
        end
        `DPC_OFF_COMMAND: begin
          // a command while a transfer runs is dropped silently
          if ((s_q.st == dpc_pkg::xf_idle) && s_q.wstrb[0]) begin
            if (s_q.wdata[`DPC_CMD_RESTORE_BIT]) begin
              s_d.st        = dpc_pkg::xf_restore;
              s_d.count     = FAC_CNT;
              s_d.act_count = FAC_CNT;
              s_d.nv_count  = FAC_CNT;
            end else if (s_q.wdata[`DPC_CMD_PERSIST_BIT]) begin
              s_d.st       = dpc_pkg::xf_persist;
              s_d.nv_count = s_q.count;
            end else if (s_q.wdata[`DPC_CMD_COMMIT_BIT]) begin
              s_d.st        = dpc_pkg::xf_commit;
              s_d.act_count = s_q.count;
            end
          end
        end
        `DPC_OFF_STATUS: ;
        default: s_d.bresp = `DPC_RESP_SLVERR;
      endcase
    end
    // read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = rd_ok ? `DPC_RESP_OKAY : `DPC_RESP_SLVERR;
    end
    // pixel stage
    if (emit) begin
      s_d.held     = 1'b0;
      s_d.left_pix = s_q.held_pix;
      s_d.left_ok  = !s_q.held_end;
    end
    if (in_fire) begin
      s_d.held     = 1'b1;
      s_d.held_pix = s_pixel;
      s_d.held_end = s_line_end;
      s_d.held_def = hit;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.en       <= `DPC_RST_EN;
      s_q.method   <= dpc_pkg::method_average;
      s_q.st       <= dpc_pkg::xf_boot;
      s_q.nv_col   <= FAC_COL;
      s_q.nv_row   <= FAC_ROW;
      s_q.nv_count <= FAC_CNT;
    end else begin
      s_q <= s_d;
    end
  end

  pixel_fifo #(
    .WIDTH (PIX_W+1),
    .DEPTH (`DPC_FIFO_DEPTH)
  ) u_out_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (emit),
    .in_ready  (fifo_in_ready),
    .in_data   ({s_q.held_end, fix_pix}),
    .out_valid (m_valid),
    .out_ready (m_ready),
    .out_data  ({m_line_end, m_pixel})
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_pass_through: assert property (emit && !s_q.en |-> fix_pix == s_q.held_pix)
    else $error("pixel altered while correction off");
  chk_zero_mode: assert property (
      emit && s_q.en && s_q.held_def && s_q.method == dpc_pkg::method_zero |-> fix_pix == '0)
    else $error("zero mode pixel not zero");
  chk_highlight_max: assert property (
      emit && s_q.en && s_q.held_def && s_q.method == dpc_pkg::method_highlight |-> fix_pix == '1)
    else $error("highlight pixel not at maximum");
  chk_average_pair: assert property (
      emit && s_q.en && s_q.held_def && s_q.method == dpc_pkg::method_average
      && s_q.left_ok && right_ok |-> fix_pix == pair_sum[PIX_W:1])
    else $error("average pixel wrong");
  chk_active_stable: assert property (
      s_q.st == dpc_pkg::xf_idle && !(wr_go && s_q.awaddr == `DPC_OFF_COMMAND)
      |=> $stable(s_q.act_col) && $stable(s_q.act_row) && $stable(s_q.act_count))
    else $error("active table changed without command");
  chk_transfer_ends: assert property (
      $rose(s_q.st != dpc_pkg::xf_idle) |-> ##[1:300] s_q.st == dpc_pkg::xf_idle)
    else $error("table transfer did not finish");
  chk_busy_refuse: assert property (
      s_q.st != dpc_pkg::xf_idle && s_q.idx != LAST_IDX |=> s_q.st == $past(s_q.st))
    else $error("command accepted during transfer");
  chk_count_write: assert property (
      wr_go && s_q.awaddr == `DPC_OFF_COUNT && s_q.wstrb == 4'hf && s_q.wdata <= 32'(ENTRIES)
      && s_q.st == dpc_pkg::xf_idle |=> s_q.count == $past(s_q.wdata[CW-1:0]))
    else $error("entry count not stored");
  chk_boot_entry: assert property ($past(sys_rst) |-> s_q.st == dpc_pkg::xf_boot && s_q.idx == '0)
    else $error("no table load after reset");
  chk_commit_copy: assert property (
      s_q.st == dpc_pkg::xf_commit |=> s_q.act_col[$past(s_q.idx)] == $past(s_q.stg_col[s_q.idx]))
    else $error("commit did not copy entry");
  // reset reloads the stored copy with the factory table before reading it back, so the bench cannot see a persist
  chk_persist_copy: assert property (
      s_q.st == dpc_pkg::xf_persist |=> s_q.nv_col[$past(s_q.idx)] == $past(s_q.stg_col[s_q.idx])
      && s_q.nv_row[$past(s_q.idx)] == $past(s_q.stg_row[s_q.idx]))
    else $error("persist did not store entry");
  chk_restore_all: assert property (
      s_q.st == dpc_pkg::xf_restore |=> s_q.nv_col[$past(s_q.idx)] == FAC_COL[$past(s_q.idx)]
      && s_q.act_col[$past(s_q.idx)] == FAC_COL[$past(s_q.idx)])
    else $error("restore left a copy unchanged");

  cov_commit_done: cover property (s_q.st == dpc_pkg::xf_commit ##1 s_q.st == dpc_pkg::xf_idle);
  cov_restore_done: cover property (s_q.st == dpc_pkg::xf_restore ##1 s_q.st == dpc_pkg::xf_idle);
  cov_avg_emit: cover property (emit && s_q.en && s_q.held_def && s_q.method == dpc_pkg::method_average);
  cov_fifo_full: cover property (s_q.held && !fifo_in_ready);
endmodule
`default_nettype wire

// [sim/pixel_sink.sv]
// Purpose: downstream image path model for the corrected pixel stream
// Assumes: one clock; takes a pixel on an edge with m_valid and m_ready high
// Notes:   stall holds m_ready low so the fifo fills up
`timescale 1ns/1ps
`default_nettype none
module pixel_sink (
  input  wire logic clock,
  input  wire logic stall,
  output logic      m_ready
);
  int seed = 56409;
  initial m_ready = 1'b0;
  // random gaps, so no steady rate can hide a handshake slip
  always @(posedge clock) begin
    m_ready <= !stall && (($random(seed) & 3) != 0);
  end
endmodule
`default_nettype wire

// [sim/tb_defect_pixel_table_control.sv]
// Purpose: self-checking bench of the defect pixel table control
// Assumes: factory table {col 3,row 1},{col 5,row 1}; pixels at full-sensor row 1 only
// Notes:   sys_rst stands for a power cycle; the stored table comes back as the factory table
`timescale 1ns/1ps
`default_nettype none
`include "dpc_cfg.svh"
module tb_defect_pixel_table_control;
  localparam int L = 24;
  logic        clock, sys_rst, awv, wv, bready, arv, rready, s_valid, s_line_end, stall, refused;
  logic        awready, wready, bvalid, arready, rvalid, s_ready, m_valid, m_ready, m_line_end;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r, b;
  logic [11:0] s_pixel, m_pixel;
  logic [15:0] s_col, roi_col, s_row, roi_row;
  logic [11:0] pix [L];
  logic [12:0] got [$];
  int          seed = 56409;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  defect_pixel_table_control #(.FACTORY_COUNT(2), .FACTORY_COLS({96'h0, 16'h0005, 16'h0003}),
    .FACTORY_ROWS({96'h0, 16'h0001, 16'h0001})) defect_pixel_table_control_inst (
    .clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_valid(s_valid),
    .s_ready(s_ready), .s_pixel(s_pixel), .s_col(s_col), .s_row(s_row), .s_line_end(s_line_end),
    .roi_offset_col(roi_col), .roi_offset_row(roi_row), .m_valid(m_valid), .m_ready(m_ready),
    .m_pixel(m_pixel), .m_line_end(m_line_end));
  pixel_sink pixel_sink_inst (.clock(clock), .stall(stall), .m_ready(m_ready));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // values sampled at the falling edge hold until the rising edge that takes them
  always @(negedge clock) begin
    if (m_valid && m_ready) got.push_back({m_line_end, m_pixel});
    if (s_valid && !s_ready) refused = 1'b1;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 50000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("counts: comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    logic pa, pw, ta, tw, tb;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a; wdata <= v; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clock);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge clock);
      if (ta) begin pa = 1'b0; awv <= 1'b0; end
      if (tw) begin pw = 1'b0; wv <= 1'b0; end
    end
    // ready stays high between transfers, so back-to-back calls never drive it twice in one step
    do begin @(negedge clock); tb = bvalid; b = bresp; @(posedge clock); end while (!tb);
  endtask
  task automatic rd(logic [7:0] a);
    logic t;
    araddr <= a; arv <= 1'b1; rready <= 1'b1;
    do begin @(negedge clock); t = arready; @(posedge clock); end while (!t);
    arv <= 1'b0;
    do begin @(negedge clock); t = rvalid; d = rdata; r = rresp; @(posedge clock); end while (!t);
  endtask
  task automatic rchk(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    rd(a);
    check("read data", e, d);
    check("read resp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic wait_idle();
    do rd(`DPC_OFF_STATUS); while (d[0] !== 1'b0);
  endtask
  task automatic pwr();
    sys_rst <= 1'b1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    wait_idle();
  endtask
  // neighbours are the raw pixels left and right in the same row
  function automatic logic [11:0] exp_pix(int i, logic [L-1:0] mk, logic en, logic [1:0] m);
    logic [12:0] s;
    if (!en || !mk[i]) return pix[i];
    if (m == 2'd1) return 12'hfff;
    if (m == 2'd2) return 12'h000;
    if (i == 0) return pix[1];
    if (i == L - 1) return pix[L-2];
    s = pix[i-1] + pix[i+1];
    return s[12:1];
  endfunction
  task automatic row(logic [15:0] off, logic [L-1:0] mk, logic en, logic [1:0] m);
    logic t;
    wr(`DPC_OFF_CTRL, {29'h0, m, en});
    roi_col <= off;
    got.delete();
    for (int i = 0; i < L; i++) pix[i] = 12'($random(seed));
    for (int i = 0; i < L; i++) begin
      s_valid <= 1'b1; s_pixel <= pix[i]; s_col <= 16'(i); s_line_end <= (i == L - 1);
      do begin @(negedge clock); t = s_ready; @(posedge clock); end while (!t);
    end
    s_valid <= 1'b0;
    for (int k = 0; k < 300 && got.size() < L; k++) @(posedge clock);
    for (int i = 0; i < L; i++) check("pixel", {19'h0, (i == L - 1), exp_pix(i, mk, en, m)}, {19'h0, got[i]});
    $display("row test done, offset %0d method %0d", off, m);
  endtask

  initial begin
    {sys_rst, awv, wv, bready, arv, rready, s_valid, s_line_end, stall, refused} = '0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; s_pixel = 12'h000; s_col = 16'h0; roi_col = 16'h0;
    s_row = 16'h1;
    roi_row = 16'h0;
    pwr();
    rchk(`DPC_OFF_STATUS, 32'h200, 2'b00);
    rchk(`DPC_OFF_COUNT, 32'h2, 2'b00);
    wr(`DPC_OFF_SELECT, 32'h1);
    check("write resp", 32'h0, {30'h0, b});
    rchk(`DPC_OFF_COLUMN, 32'h5, 2'b00);
    rchk(`DPC_OFF_ROW, 32'h1, 2'b00);
    rchk(8'h1c, 32'h0, 2'b10);
    wr(8'h1c, 32'h0);
    check("write resp", 32'h2, {30'h0, b});
    row(16'h0, 24'h28, 1'b0, 2'd0);
    for (int m = 0; m < 3; m++) row(16'h0, 24'h28, 1'b1, 2'(m));
    wr(`DPC_OFF_SELECT, 32'h0);
    wr(`DPC_OFF_COLUMN, 32'h6);
    rchk(`DPC_OFF_COLUMN, 32'h6, 2'b00);
    row(16'h0, 24'h28, 1'b1, 2'd2);
    wr(`DPC_OFF_COMMAND, 32'h1);
    // a restore taken here would bring back the factory table and fail the next row
    wr(`DPC_OFF_COMMAND, 32'h4);
    wait_idle();
    stall <= 1'b1;
    fork
      begin repeat (120) @(posedge clock); stall <= 1'b0; end
    join_none
    row(16'h0, 24'h60, 1'b1, 2'd2);
    check("fifo refused", 32'h1, {31'h0, refused});
    roi_row <= 16'h1;
    s_row <= 16'h0;
    row(16'h2, 24'h18, 1'b1, 2'd2);
    roi_row <= 16'h0;
    s_row <= 16'h1;
    pwr();
    row(16'h0, 24'h28, 1'b1, 2'd2);
    wr(`DPC_OFF_COLUMN, 32'h6);
    wr(`DPC_OFF_COMMAND, 32'h1);
    wait_idle();
    wr(`DPC_OFF_COMMAND, 32'h2);
    wait_idle();
    row(16'h0, 24'h60, 1'b1, 2'd2);
    wr(`DPC_OFF_COMMAND, 32'h4);
    wait_idle();
    row(16'h0, 24'h28, 1'b1, 2'd2);
    rchk(`DPC_OFF_COLUMN, 32'h3, 2'b00);
    pwr();
    row(16'h0, 24'h28, 1'b1, 2'd2);
    wr(`DPC_OFF_COUNT, 32'h9);
    rchk(`DPC_OFF_COUNT, 32'h8, 2'b00);
    print_verdict();
  end
endmodule
`default_nettype wire
